// File: crsic_cfg.svh
// Purpose: constants of the core reset, stack and interrupt sequencer
// Assumes: included by its bare name
// Notes:   start-up figure is in core clock cycles
`ifndef CRSIC_CFG_SVH
`define CRSIC_CFG_SVH
`define CRSIC_SP_RST    16'h013f
`define CRSIC_SP_FIXED  10'h004
`define CRSIC_SP_TOP    6'h3f
`define CRSIC_VEC_RESET 16'hfffe
`define CRSIC_VEC_TRAP  16'hfffc
`define CRSIC_VEC_IRQ0  16'hfffa
`define CRSIC_NO_IRQ    3'h6
`define CRSIC_LEN_CTX   3'h5
`define CRSIC_LEN_RET   3'h2
`define CRSIC_LEN_BYTE  3'h1
`define CRSIC_STARTUP   4096
`define CRSIC_DIV3_LAST 2'h2
`endif

// File: crsic_pkg.sv
// Purpose: types of the core reset, stack and interrupt sequencer
// Assumes: nothing
// Notes:   one packed struct holds all state of the divider, a second one all state of the core
package crsic_pkg;
  typedef enum logic [3:0] {
    CMD_CALL, CMD_RET, CMD_PUSH, CMD_POP, CMD_RSP,
    CMD_LDS, CMD_TRAP, CMD_RETURN_FROM_INTERRUPT, CMD_WFI, CMD_HALT
  } crsic_cmd_t;
  typedef enum logic [2:0] {
    ST_RHOLD, ST_RUN, ST_PUSH, ST_READ, ST_DRAIN, ST_WAIT, ST_HALT, ST_HWAKE
  } crsic_st_t;
  typedef enum logic [2:0] {
    OP_CALL, OP_INT, OP_PUSH1, OP_RET, OP_RETURN_FROM_INTERRUPT, OP_POP1, OP_VEC
  } crsic_op_t;
  typedef enum logic [2:0] {
    SL_PCL, SL_PCH, SL_X, SL_A, SL_CC, SL_DATA
  } crsic_slot_t;
  typedef struct packed {
    logic [1:0] div3;
    logic [1:0] div4;
    logic       tick;
    logic       core_clk;
    logic       usb_clk;
  } crsic_div_t;
  typedef struct packed {
    crsic_st_t   st;
    crsic_op_t   op;
    crsic_slot_t tag1;
    crsic_slot_t tag2;
    logic        tag1v;
    logic        tag2v;
    logic [5:0]  sp;
    logic [2:0]  idx;
    logic [15:0] cnt;
    logic [15:0] vec;
    logic [5:0]  pend;
    logic [15:0] pc;
    logic [7:0]  x;
    logic [7:0]  a;
    logic [7:0]  cc;
    logic [7:0]  popb;
    logic [15:0] addr;
    logic [7:0]  wdata;
    logic        we, re, pc_load, done, busy, imask, halt_l, wait_l;
    logic        osc_off, tmr_en, prst, pin_oe, rst_s1, rst_s2, lvd_s1, lvd_s2;
  } crsic_state_t;
endpackage

// File: crsic_clock_halving_select.sv
// Purpose: core and usb clocks from the oscillator clock
// Assumes: clk is the oscillator clock
// Notes:   core clock is high one cycle in three; tick marks its rise
`timescale 1ns/100ps
`default_nettype none
`include "crsic_cfg.svh"
module crsic_clock_halving_select (
  // clock and reset
  input  wire logic clk,
  input  wire logic rst_n,
  // usb divide select: 1 gives /2, 0 gives /4
  input  wire logic halve_sel,
  // derived clocks
  output logic      core_tick,
  output logic      core_clk,
  output logic      usb_clk
);
  crsic_pkg::crsic_div_t s_r;
  crsic_pkg::crsic_div_t s_nxt;

  always_comb begin
    s_nxt = s_r;
    s_nxt.tick = 1'b0;
    if (s_r.div3 == `CRSIC_DIV3_LAST) begin
      s_nxt.div3 = 2'h0;
      s_nxt.tick = 1'b1;
    end else begin
      s_nxt.div3 = s_r.div3 + 2'h1;
    end
    s_nxt.core_clk = (s_nxt.div3 == 2'h0);
    s_nxt.div4 = s_r.div4 + 2'h1;
    s_nxt.usb_clk = halve_sel ? s_nxt.div4[0] : s_nxt.div4[1];
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      s_r <= '0;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign core_tick = s_r.tick;
  assign core_clk  = s_r.core_clk;
  assign usb_clk   = s_r.usb_clk;

  a_core_div_three: assert property (@(posedge clk) disable iff (!rst_n)
    core_tick |=> !core_tick ##1 !core_tick ##1 core_tick)
    else $error("core tick not one in three");
endmodule
`default_nettype wire

// File: crsic_core.sv
// Purpose: reset sequencing, stack pointer, context save and interrupt entry
// Assumes: memory answers MEM_RE with MEM_RDATA one cycle later
// Notes:   all logic runs on the oscillator clock; core rate via tick
`timescale 1ns/100ps
`default_nettype none
`include "crsic_cfg.svh"
module crsic_core #(
  parameter int STARTUP_CYCLES = `CRSIC_STARTUP
) (
  // clock and reset
  input  wire logic        SYS_CLK,
  input  wire logic        RST_N,
  // reset sources and reset pin
  input  wire logic        EXT_RESET_N,
  input  wire logic        LVD_TRIP,
  input  wire logic        LVD_DISABLE,
  input  wire logic        WDG_RESET,
  output logic             RESET_PIN_O,
  output logic             RESET_PIN_OE,
  // clocks
  input  wire logic        CLK_HALVING_SELECT,
  output logic             CORE_CLK,
  output logic             USB_CLK,
  output logic             CORE_TICK,
  // core commands and context
  input  wire logic        CMD_VALID,
  input  wire crsic_pkg::crsic_cmd_t CMD_CODE,
  input  wire logic        INSN_END,
  input  wire logic [7:0]  DATA_IN,
  input  wire logic [15:0] PC_IN,
  input  wire logic [7:0]  X_IN,
  input  wire logic [7:0]  A_IN,
  input  wire logic [7:0]  CC_IN,
  // interrupt requests, bit 0 highest
  input  wire logic [5:0]  IRQ_IN,
  // stack and vector memory
  output logic [15:0]      MEM_ADDR,
  output logic [7:0]       MEM_WDATA,
  output logic             MEM_WE,
  output logic             MEM_RE,
  input  wire logic [7:0]  MEM_RDATA,
  // results
  output logic [15:0]      STACK_PTR,
  output logic [15:0]      CTX_PC,
  output logic [7:0]       CTX_X,
  output logic [7:0]       CTX_A,
  output logic [7:0]       CTX_CC,
  output logic [7:0]       POP_DATA,
  output logic             PC_LOAD,
  output logic             CMD_DONE,
  output logic             BUSY,
  output logic             I_MASK,
  output logic [5:0]       IRQ_PENDING,
  // power and reset side effects
  output logic             HALT_LATCH,
  output logic             WAIT_LATCH,
  output logic             OSC_OFF,
  output logic             TIMER_CLK_EN,
  output logic             PERIPH_RST
);
  crsic_pkg::crsic_state_t s_r;
  crsic_pkg::crsic_state_t s_nxt;
  logic                    core_tick;
  logic                    core_clk;
  logic                    usb_clk;
  logic                    lvd_rst;
  logic                    rst_any;
  logic [2:0]              sel;
  logic                    eligible;

  crsic_clock_halving_select u_div (
    .clk       (SYS_CLK),
    .rst_n     (RST_N),
    .halve_sel (CLK_HALVING_SELECT),
    .core_tick (core_tick),
    .core_clk  (core_clk),
    .usb_clk   (usb_clk)
  );

  // lowest set bit wins
  function automatic logic [2:0] prio_sel(input logic [5:0] p);
    prio_sel = `CRSIC_NO_IRQ;
    for (int i = 5; i >= 0; i--) begin
      if (p[i]) begin
        prio_sel = 3'(i);
      end
    end
  endfunction

  function automatic logic [2:0] op_len(input crsic_pkg::crsic_op_t op);
    case (op)
      crsic_pkg::OP_INT, crsic_pkg::OP_RETURN_FROM_INTERRUPT:  op_len = `CRSIC_LEN_CTX;
      crsic_pkg::OP_PUSH1, crsic_pkg::OP_POP1: op_len = `CRSIC_LEN_BYTE;
      default:                                 op_len = `CRSIC_LEN_RET;
    endcase
  endfunction

  function automatic crsic_pkg::crsic_slot_t rd_slot(input crsic_pkg::crsic_op_t op,
                                                     input logic [2:0] i);
    case (op)
      crsic_pkg::OP_RETURN_FROM_INTERRUPT: rd_slot = crsic_pkg::crsic_slot_t'(3'h4 - i);
      crsic_pkg::OP_POP1: rd_slot = crsic_pkg::SL_DATA;
      default:            rd_slot = crsic_pkg::crsic_slot_t'(3'h1 - i);
    endcase
  endfunction

  assign lvd_rst  = s_r.lvd_s2 && !LVD_DISABLE;
  assign rst_any  = !s_r.rst_s2 || lvd_rst || WDG_RESET;
  assign sel      = prio_sel(s_r.pend);
  assign eligible = !s_r.imask && (sel != `CRSIC_NO_IRQ);

  always_comb begin
    logic                  go_int;
    logic                  go_trap;
    logic [5:0]            ack;
    crsic_pkg::crsic_slot_t psl;
    go_int  = 1'b0;
    go_trap = 1'b0;
    ack     = 6'h00;
    psl     = crsic_pkg::SL_PCL;
    s_nxt = s_r;
    s_nxt.rst_s1  = EXT_RESET_N;
    s_nxt.rst_s2  = s_r.rst_s1;
    s_nxt.lvd_s1  = LVD_TRIP;
    s_nxt.lvd_s2  = s_r.lvd_s1;
    s_nxt.we      = 1'b0;
    s_nxt.re      = 1'b0;
    s_nxt.pc_load = 1'b0;
    s_nxt.done    = 1'b0;
    s_nxt.tag1v   = 1'b0;
    s_nxt.tag2v   = s_r.tag1v;
    s_nxt.tag2    = s_r.tag1;
    // read data lands one cycle after the strobe
    if (s_r.tag2v) begin
      case (s_r.tag2)
        crsic_pkg::SL_PCL: s_nxt.pc[7:0]  = MEM_RDATA;
        crsic_pkg::SL_PCH: s_nxt.pc[15:8] = MEM_RDATA;
        crsic_pkg::SL_X:   s_nxt.x        = MEM_RDATA;
        crsic_pkg::SL_A:   s_nxt.a        = MEM_RDATA;
        crsic_pkg::SL_CC:  s_nxt.cc       = MEM_RDATA;
        default:           s_nxt.popb     = MEM_RDATA;
      endcase
    end
    case (s_r.st)
      crsic_pkg::ST_RHOLD: begin
        if (core_tick) begin
          if (s_r.cnt == 16'(STARTUP_CYCLES - 1)) begin
            s_nxt.st     = crsic_pkg::ST_READ;
            s_nxt.op     = crsic_pkg::OP_VEC;
            s_nxt.idx    = 3'h0;
            s_nxt.vec    = `CRSIC_VEC_RESET;
            s_nxt.prst   = 1'b0;
            s_nxt.tmr_en = 1'b1;
          end else begin
            s_nxt.cnt = s_r.cnt + 16'h0001;
          end
        end
      end
      crsic_pkg::ST_RUN: begin
        if (CMD_VALID) begin
          s_nxt.idx = 3'h0;
          case (CMD_CODE)
            crsic_pkg::CMD_CALL: begin
              s_nxt.st = crsic_pkg::ST_PUSH;
              s_nxt.op = crsic_pkg::OP_CALL;
            end
            crsic_pkg::CMD_PUSH: begin
              s_nxt.st = crsic_pkg::ST_PUSH;
              s_nxt.op = crsic_pkg::OP_PUSH1;
            end
            crsic_pkg::CMD_RET: begin
              s_nxt.st = crsic_pkg::ST_READ;
              s_nxt.op = crsic_pkg::OP_RET;
            end
            crsic_pkg::CMD_POP: begin
              s_nxt.st = crsic_pkg::ST_READ;
              s_nxt.op = crsic_pkg::OP_POP1;
            end
            crsic_pkg::CMD_RETURN_FROM_INTERRUPT: begin
              s_nxt.st = crsic_pkg::ST_READ;
              s_nxt.op = crsic_pkg::OP_RETURN_FROM_INTERRUPT;
            end
            crsic_pkg::CMD_RSP: begin
              s_nxt.sp   = `CRSIC_SP_TOP;
              s_nxt.done = 1'b1;
            end
            crsic_pkg::CMD_LDS: begin
              s_nxt.sp   = DATA_IN[5:0];
              s_nxt.done = 1'b1;
            end
            crsic_pkg::CMD_TRAP: begin
              go_int  = 1'b1;
              go_trap = 1'b1;
            end
            crsic_pkg::CMD_WFI: begin
              s_nxt.st     = crsic_pkg::ST_WAIT;
              s_nxt.imask  = 1'b0;
              s_nxt.wait_l = 1'b1;
              s_nxt.done   = 1'b1;
            end
            crsic_pkg::CMD_HALT: begin
              s_nxt.st      = crsic_pkg::ST_HALT;
              s_nxt.imask   = 1'b0;
              s_nxt.halt_l  = 1'b1;
              s_nxt.osc_off = 1'b1;
              s_nxt.tmr_en  = 1'b0;
              s_nxt.done    = 1'b1;
            end
            default: begin
              s_nxt.done = 1'b1;
            end
          endcase
        end else if (INSN_END && eligible) begin
          go_int = 1'b1;
        end
      end
      crsic_pkg::ST_PUSH: begin
        if (s_r.op == crsic_pkg::OP_PUSH1) begin
          psl = crsic_pkg::SL_DATA;
        end else begin
          psl = crsic_pkg::crsic_slot_t'(s_r.idx);
        end
        case (psl)
          crsic_pkg::SL_PCL: s_nxt.wdata = PC_IN[7:0];
          crsic_pkg::SL_PCH: s_nxt.wdata = PC_IN[15:8];
          crsic_pkg::SL_X:   s_nxt.wdata = X_IN;
          crsic_pkg::SL_A:   s_nxt.wdata = A_IN;
          crsic_pkg::SL_CC:  s_nxt.wdata = {CC_IN[7:4], s_r.imask, CC_IN[2:0]};
          default:           s_nxt.wdata = DATA_IN;
        endcase
        s_nxt.we   = 1'b1;
        s_nxt.addr = {`CRSIC_SP_FIXED, s_r.sp};
        s_nxt.sp   = s_r.sp - 6'h01;
        s_nxt.idx  = s_r.idx + 3'h1;
        if (s_r.idx == op_len(s_r.op) - 3'h1) begin
          if (s_r.op == crsic_pkg::OP_INT) begin
            s_nxt.st    = crsic_pkg::ST_READ;
            s_nxt.op    = crsic_pkg::OP_VEC;
            s_nxt.idx   = 3'h0;
            s_nxt.imask = 1'b1;
          end else begin
            s_nxt.st   = crsic_pkg::ST_RUN;
            s_nxt.done = 1'b1;
          end
        end
      end
      crsic_pkg::ST_READ: begin
        s_nxt.re    = 1'b1;
        s_nxt.tag1v = 1'b1;
        s_nxt.tag1  = rd_slot(s_r.op, s_r.idx);
        s_nxt.idx   = s_r.idx + 3'h1;
        if (s_r.op == crsic_pkg::OP_VEC) begin
          s_nxt.addr = s_r.vec + {13'h0000, s_r.idx};
        end else begin
          s_nxt.addr = {`CRSIC_SP_FIXED, 6'(s_r.sp + 6'h01)};
          s_nxt.sp   = s_r.sp + 6'h01;
        end
        if (s_r.idx == op_len(s_r.op) - 3'h1) begin
          s_nxt.st = crsic_pkg::ST_DRAIN;
        end
      end
      crsic_pkg::ST_DRAIN: begin
        if (s_r.tag2v && !s_r.tag1v) begin
          s_nxt.st      = crsic_pkg::ST_RUN;
          s_nxt.done    = 1'b1;
          s_nxt.pc_load = (s_r.op != crsic_pkg::OP_POP1);
          if (s_r.op == crsic_pkg::OP_RETURN_FROM_INTERRUPT) begin
            s_nxt.imask = 1'b0;
          end
        end
      end
      crsic_pkg::ST_WAIT: begin
        if (eligible) begin
          s_nxt.wait_l = 1'b0;
          go_int       = 1'b1;
        end
      end
      crsic_pkg::ST_HALT: begin
        if (|s_r.pend[1:0]) begin
          s_nxt.st      = crsic_pkg::ST_HWAKE;
          s_nxt.osc_off = 1'b0;
          s_nxt.halt_l  = 1'b0;
          s_nxt.cnt     = 16'h0000;
        end
      end
      crsic_pkg::ST_HWAKE: begin
        if (core_tick) begin
          if (s_r.cnt == 16'(STARTUP_CYCLES - 1)) begin
            s_nxt.tmr_en = 1'b1;
            go_int       = 1'b1;
          end else begin
            s_nxt.cnt = s_r.cnt + 16'h0001;
          end
        end
      end
      default: begin
        s_nxt.st = crsic_pkg::ST_RHOLD;
      end
    endcase
    if (go_int) begin
      s_nxt.st  = crsic_pkg::ST_PUSH;
      s_nxt.op  = crsic_pkg::OP_INT;
      s_nxt.idx = 3'h0;
      if (go_trap) begin
        s_nxt.vec = `CRSIC_VEC_TRAP;
      end else begin
        s_nxt.vec = `CRSIC_VEC_IRQ0 - {12'h000, sel, 1'b0};
        ack       = 6'(6'h01 << sel);
      end
    end
    if (rst_any) begin
      s_nxt.st      = crsic_pkg::ST_RHOLD;
      s_nxt.cnt     = 16'h0000;
      s_nxt.sp      = `CRSIC_SP_TOP;
      s_nxt.imask   = 1'b1;
      s_nxt.halt_l  = 1'b0;
      s_nxt.wait_l  = 1'b0;
      s_nxt.prst    = 1'b1;
      s_nxt.tmr_en  = 1'b0;
      s_nxt.osc_off = 1'b0;
      s_nxt.tag1v   = 1'b0;
      s_nxt.tag2v   = 1'b0;
      s_nxt.we      = 1'b0;
      s_nxt.re      = 1'b0;
      s_nxt.pc_load = 1'b0;
      s_nxt.done    = 1'b0;
      s_nxt.pend    = IRQ_IN;
    end else begin
      // a request in the ack cycle is kept
      s_nxt.pend = (s_r.pend & ~ack) | IRQ_IN;
    end
    s_nxt.pin_oe = lvd_rst || WDG_RESET;
    s_nxt.busy   = (s_nxt.st != crsic_pkg::ST_RUN);
  end

  always_ff @(posedge SYS_CLK or negedge RST_N) begin
    if (!RST_N) begin
      s_r       <= '0;
      s_r.sp    <= `CRSIC_SP_TOP;
      s_r.imask <= 1'b1;
      s_r.prst  <= 1'b1;
      s_r.busy  <= 1'b1;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign RESET_PIN_O  = 1'b0;
  assign RESET_PIN_OE = s_r.pin_oe;
  assign CORE_CLK     = core_clk;
  assign USB_CLK      = usb_clk;
  assign CORE_TICK    = core_tick;
  assign MEM_ADDR     = s_r.addr;
  assign MEM_WDATA    = s_r.wdata;
  assign MEM_WE       = s_r.we;
  assign MEM_RE       = s_r.re;
  assign STACK_PTR    = {`CRSIC_SP_FIXED, s_r.sp};
  assign CTX_PC       = s_r.pc;
  assign CTX_X        = s_r.x;
  assign CTX_A        = s_r.a;
  assign CTX_CC       = s_r.cc;
  assign POP_DATA     = s_r.popb;
  assign PC_LOAD      = s_r.pc_load;
  assign CMD_DONE     = s_r.done;
  assign BUSY         = s_r.busy;
  assign I_MASK       = s_r.imask;
  assign IRQ_PENDING  = s_r.pend;
  assign HALT_LATCH   = s_r.halt_l;
  assign WAIT_LATCH   = s_r.wait_l;
  assign OSC_OFF      = s_r.osc_off;
  assign TIMER_CLK_EN = s_r.tmr_en;
  assign PERIPH_RST   = s_r.prst;

  default clocking cb @(posedge SYS_CLK);
  endclocking
  default disable iff (!RST_N);

  a_sp_upper_fixed: assert property (STACK_PTR[15:6] == `CRSIC_SP_FIXED)
    else $error("stack pointer upper bits moved");
  a_reset_sp_top: assert property (s_r.st == crsic_pkg::ST_RHOLD |-> STACK_PTR == `CRSIC_SP_RST)
    else $error("stack pointer not at top during reset");
  a_push_post_dec: assert property (MEM_WE |-> STACK_PTR[5:0] == 6'(MEM_ADDR[5:0] - 6'h01))
    else $error("push did not decrement after write");
  a_pop_pre_inc: assert property (MEM_RE && s_r.op != crsic_pkg::OP_VEC |-> STACK_PTR == MEM_ADDR)
    else $error("pop did not increment before read");
  a_int_low_first: assert property (s_r.st == crsic_pkg::ST_PUSH && s_r.op == crsic_pkg::OP_INT
    && s_r.idx == 3'h0 && !rst_any |=> MEM_WE && MEM_WDATA == $past(PC_IN[7:0]))
    else $error("interrupt entry did not write pc low first");
  a_int_five_bytes: assert property (s_r.st == crsic_pkg::ST_PUSH && s_r.op == crsic_pkg::OP_INT
    && s_r.idx == 3'h0 && !rst_any |=> MEM_WE [*5] ##1 !MEM_WE)
    else $error("interrupt entry not five bytes");
  a_entry_sets_mask: assert property (s_r.st == crsic_pkg::ST_PUSH && s_r.op == crsic_pkg::OP_INT
    && s_r.idx == 3'h4 && !rst_any |=> I_MASK && s_r.st == crsic_pkg::ST_READ)
    else $error("interrupt entry left mask clear");
  a_return_from_interrupt_clears_mask: assert property (s_r.st == crsic_pkg::ST_DRAIN && s_r.op == crsic_pkg::OP_RETURN_FROM_INTERRUPT
    && s_r.tag2v && !s_r.tag1v && !rst_any |=> !I_MASK && PC_LOAD && !BUSY)
    else $error("return from interrupt did not clear mask");
  a_return_from_interrupt_reverse: assert property (s_r.st == crsic_pkg::ST_READ && s_r.op == crsic_pkg::OP_RETURN_FROM_INTERRUPT
    && s_r.idx == 3'h0 && !rst_any |=> s_r.tag1 == crsic_pkg::SL_CC ##1 s_r.tag1 == crsic_pkg::SL_A)
    else $error("context pop order wrong");
  a_masked_waits: assert property (s_r.st == crsic_pkg::ST_RUN && !CMD_VALID && INSN_END
    && I_MASK && !rst_any |=> s_r.st == crsic_pkg::ST_RUN)
    else $error("masked interrupt was taken");
  a_trap_unmasked: assert property (s_r.st == crsic_pkg::ST_RUN && CMD_VALID && !rst_any
    && CMD_CODE == crsic_pkg::CMD_TRAP |=> s_r.op == crsic_pkg::OP_INT && s_r.vec == `CRSIC_VEC_TRAP)
    else $error("trap not entered");
  a_prio_first: assert property (s_r.st == crsic_pkg::ST_RUN && !CMD_VALID && INSN_END && eligible
    && s_r.pend[0] && !rst_any |=> s_r.vec == `CRSIC_VEC_IRQ0)
    else $error("priority not honoured");
  a_wait_clears_mask: assert property (s_r.st == crsic_pkg::ST_RUN && CMD_VALID && !rst_any
    && CMD_CODE == crsic_pkg::CMD_WFI |=> !I_MASK && WAIT_LATCH)
    else $error("wait entry kept mask");
  a_halt_stays: assert property (s_r.st == crsic_pkg::ST_HALT && s_r.pend[1:0] == 2'h0
    && !rst_any |=> s_r.st == crsic_pkg::ST_HALT)
    else $error("halt left without a wake source");
  a_wake_timer_off: assert property (s_r.st == crsic_pkg::ST_HWAKE |-> !TIMER_CLK_EN)
    else $error("timer clock ran during start-up");
  a_startup_len: assert property (s_r.st == crsic_pkg::ST_RHOLD && s_nxt.st == crsic_pkg::ST_READ
    |-> core_tick && s_r.cnt == 16'(STARTUP_CYCLES - 1) ##1 s_r.vec == `CRSIC_VEC_RESET)
    else $error("start-up delay length wrong");
  a_rst_pin_drive: assert property (WDG_RESET |=> RESET_PIN_OE && PERIPH_RST)
    else $error("reset pin not driven");

  c_int_entry: cover property (s_r.st == crsic_pkg::ST_PUSH && s_r.op == crsic_pkg::OP_INT);
  c_return_from_interrupt_done: cover property (PC_LOAD && s_r.op == crsic_pkg::OP_RETURN_FROM_INTERRUPT);
  c_halt_wake: cover property (s_r.st == crsic_pkg::ST_HWAKE ##1 s_r.st == crsic_pkg::ST_PUSH);
  c_reset_fetch: cover property (PC_LOAD && CTX_PC != 16'h0000 && s_r.op == crsic_pkg::OP_VEC);
endmodule
`default_nettype wire

// File: crsic_mem_model.sv
// Purpose: stack and vector memory beside the sequencer
// Assumes: a read strobe in cycle n is answered in cycle n+1
// Notes:   bytes start as low address bits xor a5
`timescale 1ns/100ps
`default_nettype none
module crsic_mem_model (
  // clock
  input  wire logic        clk,
  // memory port
  input  wire logic [15:0] addr,
  input  wire logic [7:0]  wdata,
  input  wire logic        we,
  input  wire logic        re,
  output logic [7:0]       rdata
);
  logic [7:0] mem [256];
  initial begin
    for (int i = 0; i < 256; i++) begin
      mem[i] = 8'(i) ^ 8'ha5;
    end
  end
  // outside a read the line shows the inverse of its last value
  always @(posedge clk) begin
    if (we) begin
      mem[addr[7:0]] <= wdata;
    end
    rdata <= re ? mem[addr[7:0]] : ~rdata;
  end
endmodule
`default_nettype wire

// File: core_reset_stack_interrupt_ctrl_bench.sv
// Purpose: self-checking bench of the sequencer
// Assumes: short start-up count of 8 core ticks
// Notes:   inputs change 1 ns after the rising edge
`timescale 1ns/100ps
`default_nettype none
module core_reset_stack_interrupt_ctrl_bench;
  logic clk = 0, rst_n = 0, wdg = 0, halve = 0, cv = 0;
  logic ern = 1, low_voltage_detector = 0, dis = 0, ie = 1;
  logic hl, wl, osc, tmr, prst, cclk, uclk, cp, up;
  logic [7:0]  cx, ca, ccc;
  logic [15:0] ce, ue;
  crsic_pkg::crsic_cmd_t code = crsic_pkg::CMD_RSP;
  logic [7:0]  din = 8'h00, rd, wd, pop, x = 8'h00;
  logic [15:0] pc = 16'h0000, addr, sp, cpc;
  logic [5:0]  irq = 6'h00, pend;
  logic        we, re, pl, done, busy, im, oe;
  logic [31:0] seed = 32'h5224;
  int miscompares = 0, checks_done = 0, cyc = 0, n;
  initial forever #2 clk = ~clk;
  crsic_core #(.STARTUP_CYCLES(8)) i_dut (.SYS_CLK(clk), .RST_N(rst_n), .EXT_RESET_N(ern),
    .LVD_TRIP(low_voltage_detector), .LVD_DISABLE(dis), .WDG_RESET(wdg), .RESET_PIN_O(), .RESET_PIN_OE(oe),
    .CLK_HALVING_SELECT(halve), .CORE_CLK(cclk), .USB_CLK(uclk), .CORE_TICK(), .CMD_VALID(cv),
    .CMD_CODE(code), .INSN_END(ie), .DATA_IN(din), .PC_IN(pc), .X_IN(x), .A_IN(~x),
    .CC_IN({x[3:0], x[7:4]}), .IRQ_IN(irq), .MEM_ADDR(addr), .MEM_WDATA(wd), .MEM_WE(we),
    .MEM_RE(re), .MEM_RDATA(rd), .STACK_PTR(sp), .CTX_PC(cpc), .CTX_X(cx), .CTX_A(ca),
    .CTX_CC(ccc), .POP_DATA(pop), .PC_LOAD(pl), .CMD_DONE(done), .BUSY(busy), .I_MASK(im),
    .IRQ_PENDING(pend), .HALT_LATCH(hl), .WAIT_LATCH(wl), .OSC_OFF(osc), .TIMER_CLK_EN(tmr),
    .PERIPH_RST(prst));
  crsic_mem_model i_mem (.clk(clk), .addr(addr), .wdata(wd), .we(we), .re(re), .rdata(rd));
  function automatic logic [31:0] xs(input logic [31:0] s);
    s = s ^ (s << 13);
    s = s ^ (s >> 17);
    return s ^ (s << 5);
  endfunction
  // vector word as the memory model holds it: high byte first
  function automatic logic [15:0] vec(input logic [15:0] v);
    return {v[7:0] ^ 8'ha5, (v[7:0] + 8'h01) ^ 8'ha5};
  endfunction
  task automatic chk(input logic [15:0] s, input logic [15:0] e);
    checks_done++;
    if (s !== e) begin
      miscompares++;
      $display("Error at %0t: seen %h expected %h", $time, s, e);
    end
  endtask
  task automatic end_of_test();
    $display("checks %0d miscompares %0d", checks_done, miscompares);
    if (miscompares == 0 && checks_done > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  task automatic step();
    @(posedge clk);
    #1;
  endtask
  task automatic wpl(output int k);
    k = 0;
    do begin step(); k++; end while (pl !== 1'b1 && k < 20000);
  endtask
  task automatic cmd(input crsic_pkg::crsic_cmd_t c);
    step();
    while (busy !== 1'b0) step();
    code = c;
    cv = 1;
    step();
    cv = 0;
    for (int k = 0; k < 20 && done !== 1'b1 && pl !== 1'b1; k++) step();
  endtask
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 30000) begin
      miscompares++;
      end_of_test();
    end
  end
  initial begin
    seed = xs(seed);
    halve = seed[0];
    repeat (15) step();
    chk(sp, 16'h013f);
    chk(im, 1'b1);
    chk(prst, 1'b1);
    chk(tmr, 1'b0);
    step();
    rst_n = 1;
    wpl(n);
    chk(cpc, vec(16'hfffe));
    chk(n >= 24 && n <= 32, 1'b1);
    chk(prst, 1'b0);
    chk(tmr, 1'b1);
    // count rising edges of both derived clocks over 12 cycles, in both usb modes
    for (int j = 0; j < 2; j++) begin
      ce = 16'h0000;
      ue = 16'h0000;
      step();
      cp = cclk;
      up = uclk;
      repeat (12) begin
        step();
        ce = ce + 16'(cclk && !cp);
        ue = ue + 16'(uclk && !up);
        cp = cclk;
        up = uclk;
      end
      chk(ce, 16'h0004);
      chk(ue, halve ? 16'h0006 : 16'h0003);
      halve = ~halve;
    end
    for (int i = 0; i < 4; i++) begin
      seed = xs(seed);
      pc = seed[15:0];
      x = seed[23:16];
      cmd(crsic_pkg::CMD_CALL);
      chk(sp, 16'h013d);
      cmd(crsic_pkg::CMD_RET);
      chk(cpc, pc);
    end
    din = 8'hc0;
    cmd(crsic_pkg::CMD_LDS);
    chk(sp, 16'h0100);
    din = seed[31:24];
    cmd(crsic_pkg::CMD_PUSH);
    chk(sp, 16'h013f);
    cmd(crsic_pkg::CMD_POP);
    chk(pop, din);
    chk(sp, 16'h0100);
    cmd(crsic_pkg::CMD_RSP);
    chk(sp, 16'h013f);
    irq = 6'h0c;
    step();
    irq = 6'h00;
    repeat (4) step();
    chk(pend, 6'h0c);
    cmd(crsic_pkg::CMD_WFI);
    chk(im, 1'b0);
    chk(wl, 1'b1);
    wpl(n);
    chk(cpc, vec(16'hfff6));
    chk(im, 1'b1);
    chk(sp, 16'h013a);
    // no instruction boundary: the pending request must wait
    ie = 0;
    cmd(crsic_pkg::CMD_RETURN_FROM_INTERRUPT);
    chk(cpc, pc);
    chk(im, 1'b0);
    chk(cx, x);
    chk(ca, 8'(~x));
    chk(ccc, {x[3:0], x[7:4]} & 8'hf7);
    irq = 6'h01;
    repeat (3) step();
    chk(busy, 1'b0);
    irq = 6'h00;
    ie = 1;
    wpl(n);
    chk(cpc, vec(16'hfffa));
    cmd(crsic_pkg::CMD_RETURN_FROM_INTERRUPT);
    chk(cpc, pc);
    wpl(n);
    chk(cpc, vec(16'hfff4));
    cmd(crsic_pkg::CMD_HALT);
    chk(hl, 1'b1);
    chk(osc, 1'b1);
    chk(tmr, 1'b0);
    chk(im, 1'b0);
    // a timer request must not end halt, a pin request must
    irq = 6'h04;
    repeat (3) step();
    chk(hl, 1'b1);
    irq = 6'h02;
    step();
    irq = 6'h00;
    wpl(n);
    chk(cpc, vec(16'hfff8));
    chk(osc, 1'b0);
    chk(tmr, 1'b1);
    cmd(crsic_pkg::CMD_TRAP);
    chk(cpc, vec(16'hfffc));
    dis = 1;
    low_voltage_detector = 1;
    repeat (4) step();
    chk(oe, 1'b0);
    chk(busy, 1'b0);
    dis = 0;
    step();
    chk(oe, 1'b1);
    low_voltage_detector = 0;
    wpl(n);
    chk(cpc, vec(16'hfffe));
    chk(n >= 24 && n <= 32, 1'b1);
    ern = 0;
    repeat (4) step();
    chk(oe, 1'b0);
    chk(prst, 1'b1);
    ern = 1;
    wpl(n);
    chk(cpc, vec(16'hfffe));
    wdg = 1;
    step();
    step();
    chk(oe, 1'b1);
    wdg = 0;
    wpl(n);
    chk(cpc, vec(16'hfffe));
    chk(sp, 16'h013f);
    end_of_test();
  end
endmodule
`default_nettype wire
